// ==== dv/tcb_bank_properties.sv ====
/*
  Checker of the configuration bank: APB answers and decoded controls.
  Assumes a bind onto the bank top, watching its ports only.
*/
`timescale 1ns/1ps
module tcb_bank_properties #(
  parameter SAMPLE_W = 24
) (
  // Clock, reset and APB
  input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire [33:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire [3:0] pstrb,
  // Decoded controls
  input wire [1:0] thermal_gain_code,
  input wire thermal_output_invert, thermal_mux_ext_sel, excitation_on, nvm_locked,
  input wire [SAMPLE_W-1:0] thermal_sample_in, thermal_sample_out,
  input wire [3:0] excitation_onehot,
  input wire [9:0] fault_uv_tenths, fault_ov_tenths
);
  localparam [33:0] A_GAIN = 34'h1_0000_00D8;
  localparam [33:0] A_GMIR = 34'h0_0000_0920;
  localparam [33:0] A_CTRL = 34'h1_0000_00DC;
  wire acc = psel & penable & pready;
  wire wr_ok = acc & pwrite & pstrb[0] & ~pslverr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_gain_wr;
    wr_ok && (paddr == A_GAIN || paddr == A_GMIR);
  endsequence
  sequence s_ctrl_wr;
    wr_ok && paddr == A_CTRL;
  endsequence
  property p_gain;
    logic [7:0] v;
    (s_gain_wr, v = pwdata[7:0]) |-> ##2 thermal_gain_code == v[1:0];
  endproperty
  property p_mux;
    logic [7:0] v;
    (s_ctrl_wr, v = pwdata[7:0]) |-> ##2 thermal_mux_ext_sel == (v[3:0] == 4'h0);
  endproperty
  property p_exc;
    logic [7:0] v;
    (s_ctrl_wr, v = pwdata[7:0]) |-> ##2 excitation_on == !v[6];
  endproperty
  chk_gain_code: assert property (p_gain)
    else $error("gain code not stored");
  chk_invert_flag: assert property
    (s_gain_wr |-> ##2 thermal_output_invert == $past(pwdata[7], 2))
    else $error("invert flag not stored");
  chk_invert_path: assert property
    (1'b1 |=> thermal_sample_out == (thermal_output_invert ?
      -$past(thermal_sample_in) : $past(thermal_sample_in)))
    else $error("sample path wrong");
  chk_mux_route: assert property (p_mux)
    else $error("mux route wrong");
  chk_current_off: assert property (p_exc)
    else $error("current enable wrong");
  chk_current_onehot: assert property
    (excitation_on == (excitation_onehot != 4'h0) && $onehot0(excitation_onehot))
    else $error("current select not one-hot");
  chk_limit_pair: assert property
    (({1'b0, fault_uv_tenths} + fault_ov_tenths) == 11'h3E8)
    else $error("limits not symmetric");
  chk_lock_refuse: assert property
    (nvm_locked && !$past(wr_ok) && acc && paddr == A_GAIN |-> pslverr)
    else $error("locked access not refused");
  chk_upper_zero: assert property
    (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("unused read bits set");
endmodule // tcb_bank_properties

bind tcb_config_bank tcb_bank_properties #(.SAMPLE_W(SAMPLE_W)) u_tcb_bank_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pstrb(pstrb), .thermal_gain_code(thermal_gain_code),
  .thermal_output_invert(thermal_output_invert), .thermal_mux_ext_sel(thermal_mux_ext_sel),
  .excitation_on(excitation_on), .nvm_locked(nvm_locked),
  .thermal_sample_in(thermal_sample_in), .thermal_sample_out(thermal_sample_out),
  .excitation_onehot(excitation_onehot), .fault_uv_tenths(fault_uv_tenths),
  .fault_ov_tenths(fault_ov_tenths));

// ==== dv/tcb_config_bank_tb.sv ====
/*
  Self-checking bench of the configuration bank over APB.
  Assumes the bank answers with zero wait states; waits are still bounded.
*/
`timescale 1ns/1ps
module tcb_config_bank_tb;
  reg pclk, presetn, psel, penable, pwrite;
  reg [33:0] paddr, e;
  reg [31:0] pwdata, r;
  reg [3:0] pstrb, m;
  reg [23:0] smp;
  reg [33:0] exq[$];
  wire pready, pslverr, inv, ext, onc, rsv, ss, eon, dg, lk, pdl, pdh, pck, tck;
  wire [31:0] prdata;
  wire [1:0] gc;
  wire [2:0] lc;
  wire [3:0] oh;
  wire [9:0] uv, ov;
  wire [23:0] sout;
  integer bad_count = 0, cmp_count = 0, i, c, n;
  localparam [203:0] AD = {34'h1_0000_0160, 34'h1_0000_015C, 34'h1_0000_0158,
    34'h1_0000_00E8, 34'h1_0000_00DC, 34'h1_0000_00D8};
  localparam [47:0] MK = 48'h7F01_0101_7F83;
  localparam [47:0] RV = 48'h0000_0000_4000;
  localparam [79:0] UV = {10'h12C, 10'h0FA, 10'h0C8, 10'h096, 10'h07D, 10'h064,
    10'h04B, 10'h032};
  tcb_config_bank u_tcb_config_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .thermal_gain_code(gc),
    .thermal_output_invert(inv), .thermal_sample_in(smp), .thermal_sample_out(sout),
    .thermal_mux_ext_sel(ext), .onchip_thermal_sensor(onc), .thermal_mux_reserved(rsv),
    .thermal_single_sided(ss), .excitation_on(eon), .excitation_onehot(oh),
    .fault_check_on(dg), .nvm_locked(lk), .pulldown_sel_lo(pdl), .pulldown_sel_hi(pdh),
    .fault_limit_code(lc), .fault_uv_tenths(uv), .fault_ov_tenths(ov),
    .pressure_input_check_off(pck), .thermal_input_check_off(tck));
  /*********************/
  /* Checks and APB    */
  /*********************/
  task bad(input [8*16:1] s);
    begin
      bad_count = bad_count + 1;
      $display("BAD %0t %0s", $time, s);
    end
  endtask
  task chk(input [31:0] g, input [31:0] x, input [8*16:1] s);
    begin
      cmp_count = cmp_count + 1;
      if (g !== x) bad(s);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task apb(input w, input [33:0] a, input [31:0] d, input [7:0] x, input er);
    begin
      @(posedge pclk);
      exq.push_back({!w, er, 24'h0, x});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        n = n + 1;
        if (n > 20) begin
          bad("no ready");
          tally_and_finish;
        end
        @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge pclk);
      #1;
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      e = exq.pop_front();
      chk(pslverr, e[32], "error flag");
      if (e[33]) chk(prdata, e[31:0], "read data");
    end
  end
  /*********************/
  /* Main sequence     */
  /*********************/
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 34'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    smp = 24'h0;
    r = $urandom(5);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      apb(0, AD[i*34+:34], 0, RV[i*8+:8], 0);
    end
    settle;
    chk({eon, oh, uv, ov}, {5'h0, 10'h032, 10'h3B6}, "reset decode");
    $display("reset values done");
    for (i = 0; i < 6; i = i + 1) begin
      r = $urandom;
      if (i == 4) r[0] = 1'b0;
      apb(1, AD[i*34+:34], r, 0, 0);
      apb(0, AD[i*34+:34], 0, r[7:0] & MK[i*8+:8], 0);
    end
    $display("write masks done");
    apb(0, 34'h0_0000_0004, 0, 0, 1);
    apb(1, 34'h1_0000_00D9, 32'hFF, 0, 1);
    apb(1, 34'h0_0000_0920, 32'h82, 0, 0);
    pstrb <= 4'h0;
    apb(1, AD[0+:34], 32'h01, 0, 0);
    pstrb <= 4'hF;
    apb(0, AD[0+:34], 0, 8'h82, 0);
    settle;
    chk({gc, inv}, 3'b101, "gain fields");
    @(posedge pclk) smp <= r[23:0];
    settle;
    chk(sout, {8'h00, 24'h00_0000 - smp}, "inverted sample");
    apb(1, AD[0+:34], 32'h03, 0, 0);
    settle;
    chk(sout, smp, "plain sample");
    $display("gain and address checks done");
    for (c = 0; c < 8; c = c + 1) begin
      m = c[1] ? 4'h5 : {2'b0, c[0], c[0]};
      apb(1, AD[34+:34], {25'h0, c[2:0], m}, 0, 0);
      apb(1, AD[170+:34], {25'h0, c[0], c[1], c[2:0], c[1:0]}, 0, 0);
      settle;
      chk(oh, c < 4 ? 4'h1 << c : 4'h0, "current code");
      chk({ext, onc, rsv}, c[1] ? 3'b001 : (c[0] ? 3'b010 : 3'b100), "mux route");
      chk({uv, ov}, {UV[c*10+:10], 10'h3E8 - UV[c*10+:10]}, "fault limits");
      chk({lc, pdh, pdl, tck, pck}, {c[2:0], c[1], c[0], c[0], c[1]}, "fault config");
    end
    $display("decode tables done");
    apb(1, AD[68+:34], 32'h1, 0, 0);
    apb(1, AD[102+:34], 32'h1, 0, 0);
    apb(1, AD[136+:34], 32'h1, 0, 0);
    settle;
    chk({ss, dg, lk}, 3'b111, "mode diag lock");
    apb(0, AD[0+:34], 0, 0, 1);
    apb(1, AD[0+:34], 32'h80, 0, 1);
    apb(0, AD[136+:34], 0, 8'h01, 0);
    apb(1, AD[136+:34], 32'h0, 0, 0);
    apb(0, AD[0+:34], 0, 8'h03, 0);
    settle;
    $display("lock checks done");
    tally_and_finish;
  end
endmodule // tcb_config_bank_tb

// ==== src/tcb_config_bank.v ====
/*
  Temperature channel configuration bank: six byte-wide configuration
  registers behind an APB slave, with decoded controls for the temperature
  front end, diagnostics and the memory lock.
  Assumes an APB master on pclk, zero-wait answers, and analog stages that
  take the decoded controls as static levels.
*/
// What this block does
// R1: Gain byte: code bits 1:0, invert bit 7.
// R2: Gain code routed unchanged to gain stage.
// R3: Invert flag inverts gain output, resets to 0.
// R4: Control byte: mux 3:0, current 6:4.
// R5: Mux 0000 external pair, 0011 on-chip sensor.
// R6: Current codes 25/50/100/500 uA, top bit off.
// R7: Mode bit 0: differential 0, single-ended 1.
// R8: Diagnostics enable bit 0, resets off.
// R9: Lock bit refuses memory access while set.
// R10: Fault config: pulldown, threshold, check disables.
// R11: Threshold code sets symmetric under/over limits.
// R12: Unused bits read zero, ignore writes.
`timescale 1ns/1ps
`include "tcb_consts.vh"

module tcb_config_bank #(
  parameter SAMPLE_W = 24
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [33:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Temperature gain stage
  output reg [1:0] thermal_gain_code,
  output reg thermal_output_invert,
  input wire [SAMPLE_W-1:0] thermal_sample_in,
  output reg [SAMPLE_W-1:0] thermal_sample_out,
  // Temperature multiplexer and excitation
  output wire thermal_mux_ext_sel,
  output wire onchip_thermal_sensor,
  output wire thermal_mux_reserved,
  output reg thermal_single_sided,
  output wire excitation_on,
  output wire [3:0] excitation_onehot,
  // Diagnostics and lock
  output reg fault_check_on,
  output reg nvm_locked,
  output reg pulldown_sel_lo,
  output reg pulldown_sel_hi,
  output reg [2:0] fault_limit_code,
  output wire [9:0] fault_uv_tenths,
  output wire [9:0] fault_ov_tenths,
  output reg pressure_input_check_off,
  output reg thermal_input_check_off
);

  /****************************************/
  /* Register storage                      */
  /****************************************/
  reg [7:0] bank_r [0:`TCB_NREG-1];

  // Write mask of each slot; unused bits never store.
  function [7:0] slot_mask;
    input [2:0] slot;
    begin
      case (slot)
        `TCB_SLOT_TGAIN: slot_mask = `TCB_MASK_TGAIN;
        `TCB_SLOT_TCTRL: slot_mask = `TCB_MASK_TCTRL;
        `TCB_SLOT_AFE: slot_mask = `TCB_MASK_AFE;
        default: slot_mask = `TCB_MASK_BIT0;
      endcase
    end
  endfunction

  // Reset value of each slot.
  function [7:0] slot_reset;
    input [2:0] slot;
    begin
      if (slot == `TCB_SLOT_TCTRL) begin
        slot_reset = `TCB_RST_TCTRL;
      end else begin
        slot_reset = `TCB_RST_ZERO;
      end
    end
  endfunction

  /****************************************/
  /* Address decode                        */
  /****************************************/
  wire [31:0] word_idx;
  reg hit;
  reg [2:0] hit_slot;

  assign word_idx = paddr[33:2];

  // Gain and control bytes also answer at their paged mirror indexes.
  always @* begin
    hit = 1'b0;
    hit_slot = `TCB_SLOT_TGAIN;
    if (paddr[1:0] == 2'h0) begin
      case (word_idx)
        `TCB_IDX_TGAIN, `TCB_IDX_TGAIN_MIR: begin // [R1]
          hit = 1'b1;
          hit_slot = `TCB_SLOT_TGAIN;
        end
        `TCB_IDX_TCTRL, `TCB_IDX_TCTRL_MIR: begin // [R4]
          hit = 1'b1;
          hit_slot = `TCB_SLOT_TCTRL;
        end
        `TCB_IDX_TMODE: begin // [R7]
          hit = 1'b1;
          hit_slot = `TCB_SLOT_TMODE;
        end
        `TCB_IDX_DIAG: begin // [R8]
          hit = 1'b1;
          hit_slot = `TCB_SLOT_DIAG;
        end
        `TCB_IDX_LOCK: begin // [R9]
          hit = 1'b1;
          hit_slot = `TCB_SLOT_LOCK;
        end
        `TCB_IDX_AFE: begin // [R10]
          hit = 1'b1;
          hit_slot = `TCB_SLOT_AFE;
        end
        default: begin
          hit = 1'b0;
          hit_slot = `TCB_SLOT_TGAIN;
        end
      endcase
    end
  end

  /****************************************/
  /* Access control                        */
  /****************************************/
  wire locked;
  wire refused;
  wire access;
  wire wr_fire;

  assign locked = bank_r[`TCB_SLOT_LOCK][`TCB_LOCK_BIT];
  // The lock byte itself stays reachable so software can unlock.
  assign refused = locked && (hit_slot != `TCB_SLOT_LOCK); // [R9]
  assign access = psel && penable;
  assign wr_fire = access && pwrite && hit && !refused && pstrb[0]; // [R9]

  // Every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = access && (!hit || refused); // [R9]

  /****************************************/
  /* Register writes                       */
  /****************************************/
  genvar g;
  generate
    for (g = 0; g < `TCB_NREG; g = g + 1) begin : g_slot
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bank_r[g] <= slot_reset(g[2:0]); // [R3] [R8] [R9] [R10]
        end else if (wr_fire && (hit_slot == g[2:0])) begin
          bank_r[g] <= pwdata[7:0] & slot_mask(g[2:0]); // [R12]
        end
      end
    end
  endgenerate

  /****************************************/
  /* Read data                             */
  /****************************************/
  reg [7:0] rd_byte;

  always @* begin
    if (hit && !refused) begin
      rd_byte = bank_r[hit_slot] & slot_mask(hit_slot); // [R12]
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= {24'h00_0000, rd_byte}; // [R12]
    end
  end

  /****************************************/
  /* Decoded controls                      */
  /****************************************/
  wire [7:0] gain_b;
  wire [7:0] mode_b;
  wire [7:0] diag_b;
  wire [7:0] afe_b;

  assign gain_b = bank_r[`TCB_SLOT_TGAIN];
  assign mode_b = bank_r[`TCB_SLOT_TMODE];
  assign diag_b = bank_r[`TCB_SLOT_DIAG];
  assign afe_b = bank_r[`TCB_SLOT_AFE];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_gain_code <= 2'h0;
      thermal_output_invert <= 1'b0;
      thermal_single_sided <= 1'b0;
      fault_check_on <= 1'b0;
      nvm_locked <= 1'b0;
      pulldown_sel_lo <= 1'b0;
      pulldown_sel_hi <= 1'b0;
      fault_limit_code <= 3'h0;
      pressure_input_check_off <= 1'b0;
      thermal_input_check_off <= 1'b0;
    end else begin
      thermal_gain_code <= gain_b[`TCB_GAIN_MSB:0]; // [R2]
      thermal_output_invert <= gain_b[`TCB_INV_BIT]; // [R3]
      thermal_single_sided <= mode_b[`TCB_SS_BIT]; // [R7]
      fault_check_on <= diag_b[`TCB_DIAG_BIT]; // [R8]
      nvm_locked <= locked; // [R9]
      pulldown_sel_lo <= afe_b[`TCB_PD_LO_BIT]; // [R10]
      pulldown_sel_hi <= afe_b[`TCB_PD_HI_BIT]; // [R10]
      fault_limit_code <= afe_b[`TCB_LIM_MSB:`TCB_LIM_LSB]; // [R10]
      pressure_input_check_off <= afe_b[`TCB_PCHK_BIT]; // [R10]
      thermal_input_check_off <= afe_b[`TCB_TCHK_BIT]; // [R10]
    end
  end

  /****************************************/
  /* Gain stage output polarity            */
  /****************************************/
  wire [SAMPLE_W-1:0] sample_neg;

  // Two's complement negation; the most negative code wraps onto itself.
  assign sample_neg = ~thermal_sample_in + {{(SAMPLE_W-1){1'b0}}, 1'b1};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_sample_out <= {SAMPLE_W{1'b0}};
    end else if (gain_b[`TCB_INV_BIT]) begin
      thermal_sample_out <= sample_neg; // [R3]
    end else begin
      thermal_sample_out <= thermal_sample_in; // [R3]
    end
  end

  /****************************************/
  /* Multiplexer, excitation and limits    */
  /****************************************/
  tcb_field_decode u_decode (
    .pclk(pclk),
    .presetn(presetn),
    .ctrl_byte(bank_r[`TCB_SLOT_TCTRL]),
    .afe_byte(afe_b),
    .mux_ext_sel(thermal_mux_ext_sel),
    .onchip_thermal_sensor(onchip_thermal_sensor),
    .mux_reserved(thermal_mux_reserved),
    .exc_on(excitation_on),
    .exc_onehot(excitation_onehot),
    .fault_uv_tenths(fault_uv_tenths),
    .fault_ov_tenths(fault_ov_tenths)
  );

endmodule // tcb_config_bank

// ==== src/tcb_consts.vh ====
/*
  Constants of the temperature channel configuration bank: register indexes,
  write masks, reset values, field positions and decode tables.
  Assumes inclusion by the bank and its field decoder only.
*/
`ifndef TCB_CONSTS_VH
`define TCB_CONSTS_VH

/****************************************/
/* Register indexes (byte address = 4x) */
/****************************************/
`define TCB_IDX_TGAIN 32'h4000_0036
`define TCB_IDX_TCTRL 32'h4000_0037
`define TCB_IDX_TMODE 32'h4000_003A
`define TCB_IDX_DIAG 32'h4000_0056
`define TCB_IDX_LOCK 32'h4000_0057
`define TCB_IDX_AFE 32'h4000_0058
`define TCB_IDX_TGAIN_MIR 32'h0000_0248
`define TCB_IDX_TCTRL_MIR 32'h0000_024C

/****************************************/
/* Storage slots, masks and reset values */
/****************************************/
`define TCB_NREG 6
`define TCB_SLOT_TGAIN 3'h0
`define TCB_SLOT_TCTRL 3'h1
`define TCB_SLOT_TMODE 3'h2
`define TCB_SLOT_DIAG 3'h3
`define TCB_SLOT_LOCK 3'h4
`define TCB_SLOT_AFE 3'h5
`define TCB_MASK_TGAIN 8'h83
`define TCB_MASK_TCTRL 8'h7F
`define TCB_MASK_BIT0 8'h01
`define TCB_MASK_AFE 8'h7F
`define TCB_RST_TCTRL 8'h40
`define TCB_RST_ZERO 8'h00

/****************************************/
/* Field positions                       */
/****************************************/
`define TCB_GAIN_MSB 1
`define TCB_INV_BIT 7
`define TCB_MUX_MSB 3
`define TCB_EXC_MSB 6
`define TCB_EXC_LSB 4
`define TCB_SS_BIT 0
`define TCB_DIAG_BIT 0
`define TCB_LOCK_BIT 0
`define TCB_PD_LO_BIT 0
`define TCB_PD_HI_BIT 1
`define TCB_LIM_MSB 4
`define TCB_LIM_LSB 2
`define TCB_PCHK_BIT 5
`define TCB_TCHK_BIT 6

/****************************************/
/* Decode tables                         */
/****************************************/
`define TCB_MUX_EXT 4'h0
`define TCB_MUX_ONCHIP 4'h3
`define TCB_LIM_FULL 10'h3E8
`define TCB_LIM_0 10'h032
`define TCB_LIM_1 10'h04B
`define TCB_LIM_2 10'h064
`define TCB_LIM_3 10'h07D
`define TCB_LIM_4 10'h096
`define TCB_LIM_5 10'h0C8
`define TCB_LIM_6 10'h0FA
`define TCB_LIM_7 10'h12C

`endif

// ==== src/tcb_field_decode.v ====
/*
  Field decoder of the temperature channel configuration bank: turns the
  stored multiplexer, excitation and threshold codes into registered controls.
  Assumes the bank feeds it the stored bytes on the same clock.
*/
`timescale 1ns/1ps
`include "tcb_consts.vh"

module tcb_field_decode (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Stored bytes
  input wire [7:0] ctrl_byte,
  input wire [7:0] afe_byte,
  // Multiplexer controls
  output reg mux_ext_sel,
  output reg onchip_thermal_sensor,
  output reg mux_reserved,
  // Excitation controls
  output reg exc_on,
  output reg [3:0] exc_onehot,
  // Fault limits in tenths of a percent of bridge_supply_level
  output reg [9:0] fault_uv_tenths,
  output reg [9:0] fault_ov_tenths
);

  wire [3:0] mux_code;
  wire [2:0] excitation_current_code;
  wire [2:0] fault_limit_code;
  reg [9:0] uv_nxt;

  assign mux_code = ctrl_byte[`TCB_MUX_MSB:0];
  assign excitation_current_code = ctrl_byte[`TCB_EXC_MSB:`TCB_EXC_LSB];
  assign fault_limit_code = afe_byte[`TCB_LIM_MSB:`TCB_LIM_LSB];

  always @* begin
    case (fault_limit_code)
      3'h0: uv_nxt = `TCB_LIM_0; // [R11]
      3'h1: uv_nxt = `TCB_LIM_1;
      3'h2: uv_nxt = `TCB_LIM_2;
      3'h3: uv_nxt = `TCB_LIM_3;
      3'h4: uv_nxt = `TCB_LIM_4;
      3'h5: uv_nxt = `TCB_LIM_5;
      3'h6: uv_nxt = `TCB_LIM_6;
      default: uv_nxt = `TCB_LIM_7;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_ext_sel <= 1'b0;
      onchip_thermal_sensor <= 1'b0;
      mux_reserved <= 1'b0;
      exc_on <= 1'b0;
      exc_onehot <= 4'h0;
      fault_uv_tenths <= `TCB_LIM_0;
      fault_ov_tenths <= `TCB_LIM_FULL - `TCB_LIM_0;
    end else begin
      mux_ext_sel <= (mux_code == `TCB_MUX_EXT); // [R5]
      onchip_thermal_sensor <= (mux_code == `TCB_MUX_ONCHIP); // [R5]
      mux_reserved <= (mux_code != `TCB_MUX_EXT) && (mux_code != `TCB_MUX_ONCHIP); // [R5]
      // A code with the top bit set switches the source off.
      exc_on <= ~excitation_current_code[2]; // [R6]
      exc_onehot <= excitation_current_code[2] ? 4'h0 :
                    (4'h1 << excitation_current_code[1:0]); // [R6]
      fault_uv_tenths <= uv_nxt; // [R11]
      fault_ov_tenths <= `TCB_LIM_FULL - uv_nxt; // [R11]
    end
  end

endmodule // tcb_field_decode
